// file: hdl/port_driver_map.svh
// Operation
// - Strong pulldown on ports one to six only while the latch holds zero.
// - Latch zero-to-one enables boost pullup for state one phases one and two.
// - Weak pullup on ports one to six, except port two under sixteen-bit addressing, whenever the latch holds one.
// - Sensed pullup only while pin is above trip level and not driven low.
// - Pin states map to fixed pullup and pulldown combinations.
// - Zero-to-one load gives two forced-high cycles, then steady high.
// - Latch zero gives output low; latch one follows applied pin level.
// - Reset sets every port latch to one.
// - Port zero pullup only while emitting ones in bus mode; else open drain.
// - Port zero latch one in general use turns both transistors off.
// - Bus select switches ports zero and two onto the address bus.
// - In bus mode the latches of ports zero and two drive nothing.
// - In bus mode port two latch holds; port zero latch fills with ones.
// - Sixteen-bit addressing drives port two ones with strong pullups.
// - Alternate functions pass only while the latch holds one.
// - Compare output pins of ports one and five bypass the latch gate.
// - Output stage samples the latch only at phase one.
`ifndef PORT_DRIVER_MAP_SVH
`define PORT_DRIVER_MAP_SVH
`define PD_LATCH_RESET 8'hff
`define PD_BUS_LOW_FILL 8'hff
`define PD_STATE_COUNT 3'h6
`define PD_STATE_ONE 3'h1
`define PD_BOOST_PHASES 2'h2
`define PD_CMP_P1_MASK 8'h1f
`define PD_CMP_P5_MASK 8'hff
`endif

// file: hdl/port_driver_pkg.sv
package port_driver_pkg;
    typedef enum logic [2:0] {
        input_low_state = 3'h0,
        input_high_state = 3'h1,
        forced_high_state = 3'h3,
        output_low_state = 3'h2
    } pin_state_t;
    typedef logic [7:0] port_byte_t;
endpackage

// file: hdl/quasi_bidir_port_driver_control.sv
`timescale 1ns/1ps
`include "port_driver_map.svh"
module quasi_bidir_port_driver_control #(
    parameter int NUM_QPORTS = 6
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic phase_two_i,
    input wire logic cycle_start_i,
    input wire logic [NUM_QPORTS:0] latch_we_i,
    input wire port_driver_pkg::port_byte_t latch_wdata_i,
    input wire logic [NUM_QPORTS*8-1:0] trip_above_i,
    input wire logic [NUM_QPORTS*8-1:0] alt_out_i,
    input wire logic [NUM_QPORTS*8-1:0] alt_enable_i,
    input wire logic compare_p1_mode_i,
    input wire logic compare_p5_mode_i,
    input wire logic bus_mode_i,
    input wire logic wide_address_i,
    input wire logic addr_phase_i,
    input wire port_driver_pkg::port_byte_t bus_low_out_i,
    input wire logic bus_low_drive_i,
    input wire port_driver_pkg::port_byte_t bus_high_out_i,
    output logic [NUM_QPORTS*8-1:0] strong_pulldown_o,
    output logic [NUM_QPORTS*8-1:0] boost_pullup_o,
    output logic [NUM_QPORTS*8-1:0] weak_pullup_o,
    output logic [NUM_QPORTS*8-1:0] sensed_pullup_o,
    output port_driver_pkg::port_byte_t p0_pulldown_o,
    output port_driver_pkg::port_byte_t p0_pullup_o,
    output port_driver_pkg::port_byte_t p0_oe_n_o,
    output logic [NUM_QPORTS*8-1:0] latch_o,
    output port_driver_pkg::port_byte_t bus_port_low_register_o,
    output logic [2:0] state_num_o
);
    import port_driver_pkg::*;

    localparam int W = NUM_QPORTS * 8;

    initial begin
        if (NUM_QPORTS < 5 || NUM_QPORTS > 6) begin
            $error("NUM_QPORTS must be 5 or 6");
        end
    end

    function automatic port_byte_t port_of(input logic [W-1:0] v,
                                           input int idx);
        return v[idx*8 +: 8];
    endfunction

    logic [2:0] state_q;
    logic [W-1:0] latch_q;
    port_byte_t p0_latch_q;
    logic [W-1:0] seen_q;
    logic [W-1:0] boost_q;
    port_byte_t p0_seen_q;
    logic [W-1:0] cmp_mask;
    logic [W-1:0] gated;
    logic [W-1:0] force_one;
    logic state_one_phase_one;
    logic state_one_phase_two;

    // Machine cycle state counter, advanced once per phase two
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= `PD_STATE_ONE;
        end else if (clk_en_i) begin
            if (cycle_start_i) begin
                state_q <= `PD_STATE_ONE;
            end else if (phase_two_i) begin
                if (state_q == `PD_STATE_COUNT) begin
                    state_q <= `PD_STATE_ONE;
                end else begin
                    state_q <= state_q + 3'h1;
                end
            end
        end
    end
    assign state_num_o = state_q;
    assign state_one_phase_one = (state_q == `PD_STATE_ONE) && !phase_two_i;
    assign state_one_phase_two = (state_q == `PD_STATE_ONE) && phase_two_i;

    // Port latches one to six
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            latch_q <= {NUM_QPORTS{`PD_LATCH_RESET}};
        end else if (clk_en_i) begin
            for (int p = 0; p < NUM_QPORTS; p++) begin
                if (latch_we_i[p+1]) begin
                    latch_q[p*8 +: 8] <= latch_wdata_i;
                end
            end
        end
    end
    assign latch_o = latch_q;

    // Port zero latch, filled with ones while the bus owns the port
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            p0_latch_q <= `PD_LATCH_RESET;
        end else if (clk_en_i) begin
            if (bus_mode_i) begin
                p0_latch_q <= `PD_BUS_LOW_FILL;
            end else if (latch_we_i[0]) begin
                p0_latch_q <= latch_wdata_i;
            end
        end
    end
    assign bus_port_low_register_o = p0_latch_q;

    // Compare output pins bypass the latch gate
    always_comb begin
        cmp_mask = '0;
        if (compare_p1_mode_i) begin
            cmp_mask[7:0] = `PD_CMP_P1_MASK;
        end
        if (compare_p5_mode_i) begin
            cmp_mask[39:32] = `PD_CMP_P5_MASK;
        end
    end

    // Alternate outputs pass only through a latch at one
    always_comb begin
        gated = latch_q & ~(alt_enable_i & ~alt_out_i);
        gated = (gated & ~cmp_mask) | (alt_out_i & cmp_mask & alt_enable_i)
            | (latch_q & cmp_mask & ~alt_enable_i);
        force_one = '0;
        if (bus_mode_i) begin
            gated[8 +: 8] = bus_high_out_i;
            force_one[8 +: 8] = wide_address_i ? bus_high_out_i : 8'h00;
        end
    end

    // Output stage samples the gated latch only in phase one
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seen_q <= '1;
        end else if (clk_en_i && !phase_two_i) begin
            seen_q <= gated;
        end
    end

    // Boost pulse on a rising latch value, covering STATE_ONE_PHASE_ONE and STATE_ONE_PHASE_TWO
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boost_q <= '0;
        end else if (clk_en_i) begin
            if (state_one_phase_one) begin
                boost_q <= gated & ~seen_q;
            end else if (!state_one_phase_two) begin
                boost_q <= '0;
            end
        end
    end

    always_comb begin
        strong_pulldown_o = ~seen_q;
        weak_pullup_o = seen_q;
        sensed_pullup_o = seen_q & trip_above_i;
        boost_pullup_o = boost_q | force_one;
        if (bus_mode_i && wide_address_i) begin
            weak_pullup_o[8 +: 8] = 8'h00;
            sensed_pullup_o[8 +: 8] = 8'h00;
        end
    end

    // Port zero: open drain in general use, push-pull on the bus
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            p0_seen_q <= `PD_LATCH_RESET;
        end else if (clk_en_i && !phase_two_i) begin
            p0_seen_q <= p0_latch_q;
        end
    end

    always_comb begin
        if (bus_mode_i) begin
            p0_pulldown_o = bus_low_drive_i ? ~bus_low_out_i : 8'h00;
            p0_pullup_o = bus_low_drive_i ? bus_low_out_i : 8'h00;
        end else begin
            p0_pulldown_o = ~p0_seen_q;
            p0_pullup_o = 8'h00;
        end
        p0_oe_n_o = ~(p0_pulldown_o | p0_pullup_o);
    end

    a_pulldown_latch: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        strong_pulldown_o == ~seen_q)
        else $error("pulldown not tied to latch");
    a_weak_follow: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !bus_mode_i |-> weak_pullup_o == seen_q)
        else $error("weak pullup wrong");
    a_sensed_gate: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (sensed_pullup_o & ~trip_above_i) == '0)
        else $error("sensed pullup without trip");
    a_boost_window: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (boost_q != '0) |-> ($past(state_one_phase_one)
        || $past(state_one_phase_one, 2)))
        else $error("boost outside state one");
    a_boost_excl: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (boost_q & ~seen_q) == '0)
        else $error("boost with pulldown");
    a_p0_fill: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && bus_mode_i |=> p0_latch_q == `PD_BUS_LOW_FILL)
        else $error("port zero not filled");
    a_p0_open: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !bus_mode_i |-> p0_pullup_o == 8'h00)
        else $error("port zero pullup in general use");
    a_p2_hold: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i && !latch_we_i[2] |=> $stable(latch_q[15:8]))
        else $error("port two latch changed");
    a_p0_float: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !bus_mode_i |-> (p0_pulldown_o & p0_seen_q) == 8'h00)
        else $error("port zero driven on one");

    // Pin state encoding of ports one to six
    a_pulldown_excl: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (strong_pulldown_o & (weak_pullup_o | sensed_pullup_o)) == '0)
        else $error("pulldown together with pullup");
    a_weak_on_one: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !bus_mode_i |-> weak_pullup_o == ~strong_pulldown_o)
        else $error("weak pullup not on a one");
    a_sensed_follow: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !bus_mode_i |-> sensed_pullup_o == (seen_q & trip_above_i))
        else $error("sensed pullup not following trip");
    a_alt_gate: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !bus_mode_i |-> (gated & ~latch_q & ~cmp_mask) == '0)
        else $error("alternate function passed a zero latch");

    // Port two on the external bus
    a_wide_weak_off: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i && wide_address_i |-> weak_pullup_o[15:8] == 8'h00)
        else $error("weak pullup on during wide address");
    a_wide_sensed_off: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i && wide_address_i |-> sensed_pullup_o[15:8] == 8'h00)
        else $error("sensed pullup on during wide address");
    a_wide_strong: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i && wide_address_i
        |-> (bus_high_out_i & ~boost_pullup_o[15:8]) == 8'h00)
        else $error("address one without strong pullup");
    a_narrow_weak: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i && !wide_address_i
        |-> weak_pullup_o[15:8] == seen_q[15:8])
        else $error("narrow address lost weak pullup");

    // Latch loading
    a_latch_hold: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && latch_we_i[NUM_QPORTS:1] == '0 |=> $stable(latch_q))
        else $error("latch changed without write");
    a_latch_load: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && latch_we_i[1] |=> latch_q[7:0] == $past(latch_wdata_i))
        else $error("port one latch not loaded");
    a_p2_load: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && latch_we_i[2] |=> latch_q[15:8] == $past(latch_wdata_i))
        else $error("port two latch not loaded");
    a_p0_load: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && !bus_mode_i && latch_we_i[0]
        |=> p0_latch_q == $past(latch_wdata_i))
        else $error("port zero latch not loaded");

    // Port zero drivers
    a_p0_bus_excl: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i |-> (p0_pulldown_o & p0_pullup_o) == 8'h00)
        else $error("port zero drives both ways");
    a_p0_oe_low: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (p0_pulldown_o & p0_oe_n_o) == 8'h00)
        else $error("port zero pulls down while released");
    a_p0_bus_pullup: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i && bus_low_drive_i |-> p0_pullup_o == bus_low_out_i)
        else $error("port zero bus ones not pulled up");
    a_p0_idle_bus: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        bus_mode_i && !bus_low_drive_i |-> p0_oe_n_o == 8'hff)
        else $error("port zero driven while bus idle");
    a_p0_general: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !bus_mode_i |-> p0_pulldown_o == ~p0_seen_q)
        else $error("port zero pulldown not following latch");

    // Boost pulse and machine cycle timing
    a_boost_len: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        $rose(boost_q != '0) |=> (boost_q != '0) ##1 (boost_q == '0))
        else $error("boost pulse not two periods");
    a_state_range: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        state_q >= `PD_STATE_ONE && state_q <= `PD_STATE_COUNT)
        else $error("state number out of range");
    a_state_step: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && !phase_two_i && !cycle_start_i |=> $stable(state_q))
        else $error("state moved in phase one");
    a_state_wrap: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && phase_two_i && !cycle_start_i
        && state_q == `PD_STATE_COUNT |=> state_q == `PD_STATE_ONE)
        else $error("state did not wrap");
    a_state_sync: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && cycle_start_i |=> state_q == `PD_STATE_ONE)
        else $error("state not resynchronised");

    // Output stage sampling
    a_seen_phase2: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && phase_two_i |=> $stable(seen_q))
        else $error("output stage sampled in phase two");
    a_seen_follow: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && !phase_two_i |=> seen_q == $past(gated))
        else $error("output stage missed phase one");
    a_p0_seen_hold: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && phase_two_i |=> $stable(p0_seen_q))
        else $error("port zero sampled in phase two");
    a_p0_seen_follow: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clk_en_i && !phase_two_i |=> p0_seen_q == $past(p0_latch_q))
        else $error("port zero missed phase one");

    c_boost: cover property (@(posedge core_clk_i) boost_q != '0);
    c_bus: cover property (@(posedge core_clk_i) bus_mode_i && wide_address_i);
    c_low: cover property (@(posedge core_clk_i) strong_pulldown_o != '0);
    c_p0_open: cover property (@(posedge core_clk_i)
        !bus_mode_i && p0_oe_n_o != 8'hff);
    c_sensed: cover property (@(posedge core_clk_i)
        !bus_mode_i && sensed_pullup_o != '0);
endmodule

// file: verification/port_load_model.sv
`timescale 1ns/1ps
module port_load_model (
    input wire logic core_clk_i,
    input wire logic [47:0] strong_pulldown_i,
    input wire logic [47:0] weak_pullup_i,
    input wire logic [47:0] boost_pullup_i,
    input wire logic [47:0] ext_low_i,
    input wire port_driver_pkg::port_byte_t p0_oe_n_i,
    input wire port_driver_pkg::port_byte_t p0_pulldown_i,
    output logic [47:0] trip_above_o,
    output port_driver_pkg::port_byte_t p0_level_o
);
    import port_driver_pkg::*;
    // Pin rises past trip only when pulled up and nothing sinks it
    always_ff @(posedge core_clk_i) begin
        trip_above_o <= ~strong_pulldown_i & (weak_pullup_i | boost_pullup_i)
            & ~ext_low_i;
    end
    // Outside pull-up holds undriven port zero lines high
    assign p0_level_o = p0_oe_n_i | ~p0_pulldown_i;
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
    import port_driver_pkg::*;
    logic core_clk_i = 0, resetn_i = 0, ph2 = 0, cstart = 0, bus = 0;
    logic [6:0] we = 0;
    port_byte_t wd = 8'h00;
    logic [47:0] trip, ext_low = 0, zero48 = 0;
    logic [47:0] pd, bst, wk, sn, lat;
    port_byte_t p0pd, p0pu, p0oe, p0reg, p0lvl;
    logic [3:0] st = 0;
    logic [2:0] st_num;
    int err_count = 0, checked = 0, cyc = 0;
    always #50 core_clk_i = ~core_clk_i;
    quasi_bidir_port_driver_control #(.NUM_QPORTS(6)) dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
        .phase_two_i(ph2), .cycle_start_i(cstart), .latch_we_i(we),
        .latch_wdata_i(wd), .trip_above_i(trip), .alt_out_i(zero48),
        .alt_enable_i(zero48), .compare_p1_mode_i(1'b0),
        .compare_p5_mode_i(1'b0), .bus_mode_i(bus), .wide_address_i(bus),
        .addr_phase_i(bus), .bus_low_out_i(wd), .bus_low_drive_i(bus),
        .bus_high_out_i(wd), .strong_pulldown_o(pd), .boost_pullup_o(bst),
        .weak_pullup_o(wk), .sensed_pullup_o(sn), .p0_pulldown_o(p0pd),
        .p0_pullup_o(p0pu), .p0_oe_n_o(p0oe), .latch_o(lat),
        .bus_port_low_register_o(p0reg), .state_num_o(st_num));
    port_load_model load (.core_clk_i(core_clk_i), .strong_pulldown_i(pd),
        .weak_pullup_i(wk), .boost_pullup_i(bst), .ext_low_i(ext_low),
        .p0_oe_n_i(p0oe), .p0_pulldown_i(p0pd), .trip_above_o(trip),
        .p0_level_o(p0lvl));
    // Phase and state sequencing of the machine cycle
    always @(posedge core_clk_i) begin
        ph2 <= ~ph2;
        st <= (st == 4'hb) ? 4'h0 : st + 4'h1;
        cstart <= (st == 4'hb);
        cyc = cyc + 1;
        if (cyc > 3000) begin
            err_count = err_count + 1;
            conclude();
        end
    end
    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input int p, input port_byte_t d);
        // Land the write at state six phase two, ahead of state one
        @(posedge core_clk_i);
        while (st_num !== 3'h6 || ph2 !== 1'b0) @(posedge core_clk_i);
        we <= 7'(1) << p;
        wd <= d;
        @(posedge core_clk_i);
        we <= 7'h00;
    endtask
    task automatic settle();
        repeat (16) @(posedge core_clk_i);
        #1;
    endtask
    task automatic boost_cycles(output int n);
        n = 0;
        repeat (16) begin
            @(posedge core_clk_i);
            #1;
            if (bst[7:0] === 8'hff) n = n + 1;
        end
    endtask
    task automatic t_reset();
        settle();
        cmp(lat, {48{1'b1}});
        cmp({p0reg, p0oe}, 16'hffff);
        cmp({pd, bst}, 96'h0);
        cmp(wk, {48{1'b1}});
        cmp({40'h0, p0pu}, 48'h0);
        $display("test reset done");
    endtask
    task automatic t_low_high();
        int n;
        wr(1, 8'h00);
        settle();
        cmp({wk[7:0], sn[7:0], pd[7:0]}, 24'h0000ff);
        cmp(lat[7:0], 8'h00);
        wr(1, 8'hff);
        boost_cycles(n);
        cmp(n, 2);
        settle();
        cmp({wk[7:0], sn[7:0], pd[7:0]}, 24'hffff00);
        wr(1, 8'hff);
        boost_cycles(n);
        cmp(n, 0);
        ext_low[7:0] <= 8'hff;
        settle();
        cmp({wk[7:0], sn[7:0]}, 16'hff00);
        ext_low[7:0] <= 8'h00;
        settle();
        cmp(sn[7:0], 8'hff);
        $display("test quasi port done");
    endtask
    task automatic t_port_zero();
        wr(0, 8'h3c);
        settle();
        cmp({p0reg, p0pd, p0pu}, 24'h3cc300);
        cmp(p0lvl, 8'h3c);
        bus <= 1'b1;
        wr(0, 8'h00);
        settle();
        cmp(p0reg, 8'hff);
        bus <= 1'b0;
        settle();
        $display("test port zero done");
    endtask
    task automatic conclude();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_low_high();
        t_port_zero();
        conclude();
    end
endmodule
